/* File: verilog/psbs_ctrl.sv */
// Host controller for a multiplexed burst pseudo-static memory
//
// Local design decisions: the register addresses and the address-and-strobe port.
`include "psbs_cfg.svh"
module psbs_ctrl #(
  parameter int PD_ENTRY_CYC = `PSBS_US_CYC(`PSBS_PD_ENTRY_US),
  parameter int PD_EXIT_CYC = `PSBS_US_CYC(`PSBS_PD_EXIT_US),
  parameter int PD_RECOV_CYC = `PSBS_US_CYC(`PSBS_PD_RECOV_US)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic mem_clk_en,
  output logic chip_select_n,
  output logic address_valid_strobe_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic [15:0] adq_out,
  output logic adq_oe,
  input wire logic [15:0] adq_in,
  input wire logic hold_off
);
  psbs_tmr_if tif();
  psbs_timer u_timer (.clk(clk), .sys_rst(sys_rst), .t(tif));

  psbs_pkg::psbs_state_t state;
  logic [15:0] bus_config_reg;
  logic [5:0] burst_len;
  logic [15:0] addr_hi;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic is_write;
  logic busy;
  logic done_flag;
  logic rd_valid;
  logic low_err;
  logic pd_active;
  logic [2:0] lat_cnt;
  logic [5:0] word_cnt;
  logic [7:0] low_cnt;
  logic cmd_go;
  logic [2:0] cmd_kind;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
    is_reg = (a == r);
  endfunction

  wire logic [2:0] latency_code =
    bus_config_reg[`PSBS_CFG_LC_HI:`PSBS_CFG_LC_LO];
  wire logic hold_active = !hold_off;
  // Select window of a burst; the last word keeps select low until its edge
  wire logic sel_burst = state == psbs_pkg::PSBS_ADDR ||
                         state == psbs_pkg::PSBS_LAT ||
                         (state == psbs_pkg::PSBS_DATA &&
                          !(word_cnt + 6'h01 >= burst_len && !hold_active));

  // Command decode
  always_comb
  begin
    cmd_go = 1'b0;
    cmd_kind = 3'h0;
    if (reg_wr && is_reg(reg_addr, `PSBS_REG_CTRL) && !busy)
    begin
      cmd_go = 1'b1;
      if (reg_wdata[`PSBS_CMD_WR])
        cmd_kind = 3'h1;
      else if (reg_wdata[`PSBS_CMD_PD])
        cmd_kind = 3'h2;
      else if (reg_wdata[`PSBS_CMD_WAKE])
        cmd_kind = 3'h3;
      else if (reg_wdata[`PSBS_CMD_RD])
        cmd_kind = 3'h0;
      else
        cmd_go = 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_config_reg <= `PSBS_CFG_RESET;
      burst_len <= `PSBS_BLEN_RESET;
      addr_hi <= 16'h0000;
      wdata <= 16'h0000;
    end
    else if (reg_wr)
    begin
      if (is_reg(reg_addr, `PSBS_REG_CFG))
        bus_config_reg <= reg_wdata;
      else if (is_reg(reg_addr, `PSBS_REG_ADDR))
        addr_hi <= reg_wdata;
      else if (is_reg(reg_addr, `PSBS_REG_WDATA))
        wdata <= reg_wdata;
      else if (is_reg(reg_addr, `PSBS_REG_BLEN))
        burst_len <= reg_wdata[5:0];
    end
  end

  // Register read port, data one cycle later
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (is_reg(reg_addr, `PSBS_REG_CFG))
        reg_rdata <= bus_config_reg;
      else if (is_reg(reg_addr, `PSBS_REG_ADDR))
        reg_rdata <= addr_hi;
      else if (is_reg(reg_addr, `PSBS_REG_WDATA))
        reg_rdata <= wdata;
      else if (is_reg(reg_addr, `PSBS_REG_RDATA))
        reg_rdata <= rdata;
      else if (is_reg(reg_addr, `PSBS_REG_BLEN))
        reg_rdata <= {10'h000, burst_len};
      else if (is_reg(reg_addr, `PSBS_REG_STATUS))
        reg_rdata <= {11'h000, low_err, pd_active, rd_valid, done_flag, busy};
      else
        reg_rdata <= 16'h0000;
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Timer loads for power-down waits
  always_comb
  begin
    tif.load = 1'b0;
    tif.count = 16'h0000;
    if (cmd_go && cmd_kind == 3'h2)
    begin
      tif.load = 1'b1;
      tif.count = 16'(PD_ENTRY_CYC);
    end
    else if (cmd_go && cmd_kind == 3'h3)
    begin
      tif.load = 1'b1;
      tif.count = 16'(PD_EXIT_CYC);
    end
    else if (state == psbs_pkg::PSBS_WAKE_LOW && tif.done)
    begin
      tif.load = 1'b1;
      tif.count = 16'(PD_RECOV_CYC);
    end
  end

  // Sequencer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= psbs_pkg::PSBS_IDLE;
      is_write <= 1'b0;
      busy <= 1'b0;
      lat_cnt <= 3'h0;
      word_cnt <= 6'h00;
      pd_active <= 1'b0;
    end
    else
    begin
      case (state)
        psbs_pkg::PSBS_IDLE:
          if (cmd_go)
          begin
            busy <= 1'b1;
            is_write <= (cmd_kind == 3'h1);
            if (cmd_kind == 3'h2)
            begin
              pd_active <= 1'b1;
              state <= psbs_pkg::PSBS_PD_HOLD;
            end
            else if (cmd_kind == 3'h3)
              state <= psbs_pkg::PSBS_WAKE_LOW;
            else if (!pd_active)
              state <= psbs_pkg::PSBS_ADDR;
            else
              busy <= 1'b0;
          end
        psbs_pkg::PSBS_ADDR:
        begin
          lat_cnt <= latency_code;
          word_cnt <= 6'h00;
          state <= psbs_pkg::PSBS_LAT;
        end
        psbs_pkg::PSBS_LAT:
          if (lat_cnt == 3'h0)
            state <= psbs_pkg::PSBS_DATA;
          else
            lat_cnt <= lat_cnt - 3'h1;
        psbs_pkg::PSBS_DATA:
          // Row crossing stretches the burst while hold-off is active
          if (!hold_active)
          begin
            word_cnt <= word_cnt + 6'h01;
            if (word_cnt + 6'h01 >= burst_len)
              state <= psbs_pkg::PSBS_GAP;
          end
          else if (low_cnt >= 8'(`PSBS_MAX_LOW_CYC - 3))
            state <= psbs_pkg::PSBS_GAP;
        psbs_pkg::PSBS_GAP:
        begin
          busy <= 1'b0;
          state <= psbs_pkg::PSBS_IDLE;
        end
        psbs_pkg::PSBS_PD_HOLD:
          if (tif.done)
          begin
            busy <= 1'b0;
            state <= psbs_pkg::PSBS_IDLE;
          end
        psbs_pkg::PSBS_WAKE_LOW:
          if (tif.done)
            state <= psbs_pkg::PSBS_RECOVER;
        psbs_pkg::PSBS_RECOVER:
          if (tif.done)
          begin
            pd_active <= 1'b0;
            busy <= 1'b0;
            state <= psbs_pkg::PSBS_IDLE;
          end
        default:
          state <= psbs_pkg::PSBS_IDLE;
      endcase
    end
  end

  // Pin drive
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chip_select_n <= 1'b1;
      address_valid_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      adq_out <= 16'h0000;
      adq_oe <= 1'b0;
      mem_clk_en <= 1'b0;
    end
    else
    begin
      chip_select_n <= !(sel_burst ||
                         state == psbs_pkg::PSBS_WAKE_LOW);
      address_valid_strobe_n <= !(state == psbs_pkg::PSBS_ADDR);
      // Write enable and bus drive end with select, never after it
      write_enable_n <= !(sel_burst && is_write);
      output_enable_n <= !(sel_burst && !is_write &&
                           state != psbs_pkg::PSBS_ADDR);
      adq_oe <= sel_burst && (state == psbs_pkg::PSBS_ADDR || is_write);
      adq_out <= (state == psbs_pkg::PSBS_ADDR) ? addr_hi : wdata;
      // Clock runs in every state except PSBS_PD_HOLD, PSBS_WAKE_LOW and PSBS_RECOVER so select high is sampled at idle
      mem_clk_en <= (state != psbs_pkg::PSBS_PD_HOLD &&
                     state != psbs_pkg::PSBS_WAKE_LOW &&
                     state != psbs_pkg::PSBS_RECOVER);
    end
  end

  // Select-low watchdog and status flags; set beats clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      low_cnt <= 8'h00;
      low_err <= 1'b0;
      done_flag <= 1'b0;
      rd_valid <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      if (chip_select_n || state == psbs_pkg::PSBS_WAKE_LOW)
        low_cnt <= 8'h00;
      else
        low_cnt <= low_cnt + 8'h01;
      if (low_cnt >= 8'(`PSBS_MAX_LOW_CYC - 1))
        low_err <= 1'b1;
      else if (reg_wr && is_reg(reg_addr, `PSBS_REG_STATUS))
        low_err <= 1'b0;
      if (state == psbs_pkg::PSBS_GAP)
        done_flag <= 1'b1;
      else if (cmd_go)
        done_flag <= 1'b0;
      // Only words inside the burst length are captured
      if (state == psbs_pkg::PSBS_DATA && !is_write && hold_off &&
          word_cnt < burst_len)
      begin
        rdata <= adq_in;
        rd_valid <= 1'b1;
      end
      else if (reg_rd && is_reg(reg_addr, `PSBS_REG_RDATA))
        rd_valid <= 1'b0;
    end
  end
endmodule

/* File: inc/psbs_cfg.svh */
// Constants for the multiplexed burst pseudo-static memory controller
// Overview of operation
// - Chip select low at most 4 us
// - Select high on clock edge gives refresh
// - Select high 5 ns between bursts
// - Power-down: clear config bit 4, hold high 150 us
// - Power-down exit: select low 10 us
// - Wait 150 us after exit before commands
// - Raise select within two/three clocks of hold-off
// - Defined write: select high after last word
// - Select high between async and variable bursts
// - Sync mode: 5 ns high between async ops
`ifndef PSBS_CFG_SVH
`define PSBS_CFG_SVH
`define PSBS_CLK_MHZ 25
`define PSBS_MAX_LOW_NS 4000
`define PSBS_MAX_LOW_CYC ((`PSBS_MAX_LOW_NS * `PSBS_CLK_MHZ) / 1000)
`define PSBS_GAP_NS 5
`define PSBS_GAP_CYC 1
`define PSBS_PD_ENTRY_US 150
`define PSBS_PD_EXIT_US 10
`define PSBS_PD_RECOV_US 150
`define PSBS_US_CYC(us) ((us) * `PSBS_CLK_MHZ)
`define PSBS_REG_CTRL 4'h0
`define PSBS_REG_CFG 4'h1
`define PSBS_REG_ADDR 4'h2
`define PSBS_REG_WDATA 4'h3
`define PSBS_REG_RDATA 4'h4
`define PSBS_REG_STATUS 4'h5
`define PSBS_REG_BLEN 4'h6
`define PSBS_CMD_RD 0
`define PSBS_CMD_WR 1
`define PSBS_CMD_PD 2
`define PSBS_CMD_WAKE 3
`define PSBS_CMD_ASYNC 4
`define PSBS_CFG_PD_BIT 4
`define PSBS_CFG_WAITCFG_BIT 8
`define PSBS_CFG_LC_HI 13
`define PSBS_CFG_LC_LO 11
`define PSBS_CFG_FIXED_BIT 14
`define PSBS_CFG_ASYNC_BIT 15
`define PSBS_CFG_RESET 16'h9d1f
`define PSBS_BLEN_RESET 6'h04
`endif

/* File: inc/psbs_pkg.sv */
// Types shared by the memory controller
package psbs_pkg;
  typedef enum logic [3:0] {
    PSBS_IDLE,
    PSBS_ADDR,
    PSBS_LAT,
    PSBS_DATA,
    PSBS_GAP,
    PSBS_PD_HOLD,
    PSBS_WAKE_LOW,
    PSBS_RECOVER
  } psbs_state_t;
endpackage

/* File: inc/psbs_tmr_if.sv */
// Timer request and expiry signals between controller and its timer
interface psbs_tmr_if;
  logic load;
  logic [15:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

/* File: verilog/psbs_timer.sv */
// Down counter for long power-down waits
module psbs_timer (
  input wire logic clk,
  input wire logic sys_rst,
  psbs_tmr_if.tmr t
);
  logic [15:0] cnt;
  logic run;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt <= 16'h0000;
      run <= 1'b0;
    end
    else if (t.load)
    begin
      cnt <= t.count;
      run <= 1'b1;
    end
    else if (run && cnt != 16'h0000)
      cnt <= cnt - 16'h0001;
    else
      run <= 1'b0;
  end

  assign t.done = run && (cnt == 16'h0000);
endmodule

/* File: tb/psbs_ctrl_properties.sv */
// Pin sequencing checker for the memory controller
module psbs_chk #(
  parameter int PD_ENTRY_CYC = 20,
  parameter int PD_EXIT_CYC = 20,
  parameter int PD_RECOV_CYC = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_clk_en,
  input wire logic chip_select_n,
  input wire logic address_valid_strobe_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic adq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] low_cnt;
  logic [15:0] hi_cnt;
  logic woke;
  // Saturate so a stuck select cannot wrap back into range
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_cnt <= 16'h0000;
    else if (chip_select_n)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff)
      low_cnt <= low_cnt + 16'h0001;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hi_cnt <= 16'h0000;
    else if (!chip_select_n)
      hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hffff)
      hi_cnt <= hi_cnt + 16'h0001;
  end
  // Marks the high time that follows a wake-up low pulse
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      woke <= 1'b0;
    else
      woke <= chip_select_n & (woke | (low_cnt != 0 && !mem_clk_en));
  end
  sequence sel_release;
    !chip_select_n ##1 chip_select_n;
  endsequence
  sequence wake_start;
    $fell(chip_select_n) ##0 !mem_clk_en;
  endsequence
  sel_low_max_a: assert property (low_cnt <= 16'h0064)
    else $error("select held low too long");
  sel_release_a: assert property (sel_release |-> !adq_oe && write_enable_n)
    else $error("bus still driven after select release");
  strobe_in_sel_a: assert property (!address_valid_strobe_n |-> !chip_select_n)
    else $error("strobe low without select");
  entry_high_a: assert property (wake_start |-> hi_cnt >= PD_ENTRY_CYC)
    else $error("power-down entry high time short");
  exit_low_a: assert property ($rose(chip_select_n) && !mem_clk_en |->
    low_cnt >= PD_EXIT_CYC)
    else $error("wake pulse too short");
  recover_a: assert property ($fell(chip_select_n) && woke |->
    hi_cnt >= PD_RECOV_CYC)
    else $error("command before wake recovery");
  no_fight_a: assert property (!output_enable_n |-> !adq_oe)
    else $error("bus driven while memory outputs");
  we_in_sel_a: assert property (!write_enable_n |-> !chip_select_n)
    else $error("write enable without select");
endmodule
bind psbs_ctrl psbs_chk #(
  .PD_ENTRY_CYC(PD_ENTRY_CYC),
  .PD_EXIT_CYC(PD_EXIT_CYC),
  .PD_RECOV_CYC(PD_RECOV_CYC)
) chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .mem_clk_en(mem_clk_en),
  .chip_select_n(chip_select_n),
  .address_valid_strobe_n(address_valid_strobe_n),
  .output_enable_n(output_enable_n),
  .write_enable_n(write_enable_n),
  .adq_oe(adq_oe)
);

/* File: tb/psbs_mem_model.sv */
// Behavioural burst memory on the far side of the controller
module psbs_mem #(
  parameter int LC = 3,
  parameter int BLEN = 4
) (
  input wire logic clk,
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic adq_oe,
  input wire logic [15:0] adq_out,
  output logic [15:0] adq_in,
  output logic hold_off
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int wr_cnt = 0;
  int refreshes = 0;
  logic [15:0] wr_last = 16'h0000;
  logic [15:0] base = 16'h0000;
  initial adq_in = 16'h0000;
  initial hold_off = 1'b1;
  always @(posedge clk)
  begin
    if (chip_select_n)
    begin
      cnt <= 0;
      refreshes <= refreshes + 1;
    end
    else
    begin
      cnt <= cnt + 1;
      if (cnt == 0)
      begin
        base <= adq_out;
        wr_cnt <= 0;
      end
      // Words are counted against the burst length
      if (!write_enable_n && adq_oe && cnt >= LC + 2 && cnt < LC + 2 + BLEN)
      begin
        wr_cnt <= wr_cnt + 1;
        wr_last <= adq_out;
      end
    end
    hold_off <= !(!chip_select_n && cnt >= 1 && cnt <= LC);
    if (!chip_select_n && cnt >= LC + 1 && cnt < LC + 1 + BLEN)
      adq_in <= base + 16'(cnt - LC - 1);
    else
      adq_in <= ~adq_in;
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the memory controller
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: %h %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, adq_out, adq_in, q;
  logic mem_clk_en, chip_select_n, address_valid_strobe_n;
  logic output_enable_n, write_enable_n, adq_oe, hold_off;
  int num_errors = 0;
  int n_tests = 0;
  initial forever #20 clk = ~clk;
  psbs_ctrl #(.PD_ENTRY_CYC(20), .PD_EXIT_CYC(20), .PD_RECOV_CYC(20)) dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_clk_en(mem_clk_en),
    .chip_select_n(chip_select_n),
    .address_valid_strobe_n(address_valid_strobe_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .adq_out(adq_out), .adq_oe(adq_oe), .adq_in(adq_in),
    .hold_off(hold_off));
  psbs_mem #(.LC(3), .BLEN(4)) mem (
    .clk(clk), .chip_select_n(chip_select_n),
    .write_enable_n(write_enable_n), .adq_oe(adq_oe),
    .adq_out(adq_out), .adq_in(adq_in), .hold_off(hold_off));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Polls status until the masked bits match, bounded
  task automatic wait_st(input logic [15:0] m, input logic [15:0] v);
    int i;
    for (i = 0; i < 300; i++)
    begin
      rd(4'h5);
      if ((q & m) === v)
        break;
    end
    `CHK(q & m, v)
  endtask
  task automatic t_regs();
    rd(4'h1);
    `CHK(q, 16'h9d1f)
    rd(4'h6);
    `CHK(q, 16'h0004)
    rd(4'hf);
    `CHK(q, 16'h0000)
  endtask
  task automatic t_write();
    wr(4'h1, 16'h1d1f);
    wr(4'h2, 16'h0120);
    wr(4'h3, 16'hc3a7);
    wr(4'h0, 16'h0002);
    wait_st(16'h0003, 16'h0002);
    `CHK(mem.wr_cnt, 4)
    `CHK(mem.wr_last, 16'hc3a7)
  endtask
  task automatic t_read();
    wr(4'h0, 16'h0001);
    wait_st(16'h0007, 16'h0006);
    rd(4'h4);
    `CHK(q, 16'h0123)
  endtask
  task automatic t_pd();
    wr(4'h1, 16'h1d0f);
    wr(4'h0, 16'h0004);
    wait_st(16'h0009, 16'h0008);
    `CHK(chip_select_n, 1'b1)
    // A burst while powered down must be dropped
    wr(4'h0, 16'h0001);
    repeat (5) @(posedge clk);
    `CHK(chip_select_n, 1'b1)
    wr(4'h0, 16'h0008);
    wait_st(16'h0009, 16'h0000);
    t_read();
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_write();
    t_read();
    t_pd();
    stop_test();
  end
endmodule
